/* File: shared/aptx_pkg.sv */
package aptx_pkg;

    // instruction word and data widths
    localparam int INSN_W = 10;
    localparam int NIB_W = 4;
    localparam int BYTE_W = 8;
    localparam int RAM_AW = 9;

    // opcodes of the accumulator-to-peripheral transfer group
    localparam logic [9:0] OP_PORT_DRV3 = 10'h22b;
    localparam logic [9:0] OP_INT_CTRL1 = 10'h217;
    localparam logic [9:0] OP_INT_EN1 = 10'h03f;
    localparam logic [9:0] OP_INT_EN2 = 10'h03e;
    localparam logic [9:0] OP_WAKE0 = 10'h21b;
    localparam logic [9:0] OP_WAKE1 = 10'h214;
    localparam logic [9:0] OP_WAKE2 = 10'h215;
    localparam logic [9:0] OP_WAKE3 = 10'h22c;
    localparam logic [9:0] OP_LCD1 = 10'h20a;
    localparam logic [9:0] OP_LCD2 = 10'h20b;
    localparam logic [9:0] OP_LCD3 = 10'h20c;
    localparam logic [9:0] OP_LCD_TIMER = 10'h20d;
    localparam logic [9:0] OP_CLK_MAIN = 10'h216;
    localparam logic [9:0] OP_TMR_BIT = 10'h2aa;
    localparam logic [9:0] OP_PRESCALE = 10'h235;
    localparam logic [9:0] OP_PULLUP0 = 10'h22d;
    localparam logic [9:0] OP_PULLUP1 = 10'h22e;
    localparam logic [9:0] OP_PULLUP2 = 10'h22f;
    localparam logic [9:0] OP_PULLUP3 = 10'h208;
    localparam logic [9:0] OP_TMR1_RELOAD = 10'h23f;
    localparam logic [9:0] OP_CLK_AUX = 10'h209;
    localparam logic [9:0] OP_TMR_CTRL1 = 10'h20e;
    localparam logic [9:0] OP_TMR_CTRL2 = 10'h20f;
    // store-acc-to-ram: upper six bits fixed, low four are the immediate
    localparam logic [5:0] OP_STORE_HI = 6'h2b;

    // reset values
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_AUX = 3'h0;

    // control register index in the 4-bit bank
    typedef enum logic [4:0] {
        APTX_R_PORT_DRV3 = 5'd0,
        APTX_R_INT_CTRL1 = 5'd1,
        APTX_R_INT_EN1 = 5'd2,
        APTX_R_INT_EN2 = 5'd3,
        APTX_R_WAKE0 = 5'd4,
        APTX_R_WAKE1 = 5'd5,
        APTX_R_WAKE2 = 5'd6,
        APTX_R_WAKE3 = 5'd7,
        APTX_R_LCD1 = 5'd8,
        APTX_R_LCD2 = 5'd9,
        APTX_R_LCD3 = 5'd10,
        APTX_R_CLK_MAIN = 5'd11,
        APTX_R_PULLUP0 = 5'd12,
        APTX_R_PULLUP1 = 5'd13,
        APTX_R_PULLUP2 = 5'd14,
        APTX_R_PULLUP3 = 5'd15,
        APTX_R_TMR_CTRL1 = 5'd16,
        APTX_R_TMR_CTRL2 = 5'd17
    } aptx_reg_t;
    localparam int NREG = 18;

    // apb map: nibble registers at 4*index; wide ones follow
    localparam logic [7:0] ADDR_LCD_TIMER = 8'h48;
    localparam logic [7:0] ADDR_LCD_RELOAD = 8'h4c;
    localparam logic [7:0] ADDR_PRESCALE = 8'h50;
    localparam logic [7:0] ADDR_PRE_RELOAD = 8'h54;
    localparam logic [7:0] ADDR_TMR1_RELOAD = 8'h58;
    localparam logic [7:0] ADDR_CLK_AUX = 8'h5c;
    localparam logic [7:0] ADDR_TMR_BIT = 8'h60;
    localparam logic [7:0] ADDR_X = 8'h64;
    localparam logic [7:0] ADDR_STATUS = 8'h68;

endpackage : aptx_pkg

/* File: verilog/aptx_decode.sv */
`timescale 1ns/1ps
`default_nettype none

// pure opcode decoder, one-hot onto the register bank
module aptx_decode
(
    // instruction
    input wire logic [aptx_pkg::INSN_W-1:0] i_insn,
    input wire logic i_valid,
    // decoded strobes
    output logic [aptx_pkg::NREG-1:0] o_nib_wr,
    output logic o_lcd_timer_wr,
    output logic o_prescale_wr,
    output logic o_tmr1_reload_wr,
    output logic o_clk_aux_wr,
    output logic o_tmr_bit_wr,
    output logic o_store_wr,
    output logic o_hit
);
    import aptx_pkg::*;

    function automatic logic op_is(input logic [9:0] w, input logic [9:0] op);
        op_is = (w == op);
    endfunction : op_is

    wire logic [9:0] w = i_insn;
    wire logic [NREG-1:0] nib;

    assign nib[APTX_R_PORT_DRV3] = op_is(w, OP_PORT_DRV3);
    assign nib[APTX_R_INT_CTRL1] = op_is(w, OP_INT_CTRL1);
    assign nib[APTX_R_INT_EN1] = op_is(w, OP_INT_EN1);
    assign nib[APTX_R_INT_EN2] = op_is(w, OP_INT_EN2);
    assign nib[APTX_R_WAKE0] = op_is(w, OP_WAKE0);
    assign nib[APTX_R_WAKE1] = op_is(w, OP_WAKE1);
    assign nib[APTX_R_WAKE2] = op_is(w, OP_WAKE2);
    assign nib[APTX_R_WAKE3] = op_is(w, OP_WAKE3);
    assign nib[APTX_R_LCD1] = op_is(w, OP_LCD1);
    assign nib[APTX_R_LCD2] = op_is(w, OP_LCD2);
    assign nib[APTX_R_LCD3] = op_is(w, OP_LCD3);
    assign nib[APTX_R_CLK_MAIN] = op_is(w, OP_CLK_MAIN);
    assign nib[APTX_R_PULLUP0] = op_is(w, OP_PULLUP0);
    assign nib[APTX_R_PULLUP1] = op_is(w, OP_PULLUP1);
    assign nib[APTX_R_PULLUP2] = op_is(w, OP_PULLUP2);
    assign nib[APTX_R_PULLUP3] = op_is(w, OP_PULLUP3);
    assign nib[APTX_R_TMR_CTRL1] = op_is(w, OP_TMR_CTRL1);
    assign nib[APTX_R_TMR_CTRL2] = op_is(w, OP_TMR_CTRL2);

    assign o_nib_wr = i_valid ? nib : '0;
    assign o_lcd_timer_wr = i_valid & op_is(w, OP_LCD_TIMER);
    assign o_prescale_wr = i_valid & op_is(w, OP_PRESCALE);
    assign o_tmr1_reload_wr = i_valid & op_is(w, OP_TMR1_RELOAD);
    assign o_clk_aux_wr = i_valid & op_is(w, OP_CLK_AUX);
    assign o_tmr_bit_wr = i_valid & op_is(w, OP_TMR_BIT);
    assign o_store_wr = i_valid & (w[9:4] == OP_STORE_HI);
    assign o_hit = (|o_nib_wr) | o_lcd_timer_wr | o_prescale_wr | o_tmr1_reload_wr
        | o_clk_aux_wr | o_tmr_bit_wr | o_store_wr;

endmodule : aptx_decode

`default_nettype wire

/* File: verilog/aptx_apb.sv */
`timescale 1ns/1ps
`default_nettype none

// apb slave: zero wait state, read mux supplied by the parent
module aptx_apb
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    // register side
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_ok,
    output logic o_wr_en,
    output logic [7:0] o_wr_addr,
    output logic [31:0] o_wr_data
);
    // answer registered from the setup cycle: it stands for the first access
    // cycle with no wait state, and a read sees state as it was at setup
    wire logic setup = i_psel & ~i_penable;
    wire logic access = i_psel & i_penable;
    logic ready_reg;
    logic err_reg;
    logic [31:0] rdata_reg;

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ready_reg <= setup;
            err_reg <= setup & ~i_rd_ok;
            rdata_reg <= (setup & ~i_pwrite & i_rd_ok) ? i_rd_data : 32'h0000_0000;
        end
    end

    assign o_pready = ready_reg;
    assign o_pslverr = err_reg;
    assign o_prdata = rdata_reg;
    assign o_wr_en = access & ready_reg & i_pwrite & i_rd_ok;
    assign o_wr_addr = i_paddr;
    assign o_wr_data = i_pwdata;

endmodule : aptx_apb

`default_nettype wire

/* File: verilog/aptx_xfer.sv */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module aptx_xfer
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // core instruction stream
    input wire logic i_insn_valid,
    input wire logic [aptx_pkg::INSN_W-1:0] i_insn,
    input wire logic [aptx_pkg::NIB_W-1:0] i_acc,
    input wire logic [aptx_pkg::NIB_W-1:0] i_b,
    input wire logic [aptx_pkg::RAM_AW-1:0] i_data_pointer,
    input wire logic i_carry,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    // ram write port
    output logic o_ram_we,
    output logic [aptx_pkg::RAM_AW-1:0] o_ram_addr,
    output logic [aptx_pkg::NIB_W-1:0] o_ram_wdata,
    // core side effects
    output logic [aptx_pkg::NIB_W-1:0] o_x,
    output logic o_carry,
    output logic o_skip,
    output logic o_done,
    // control register contents
    output logic [aptx_pkg::NREG*aptx_pkg::NIB_W-1:0] o_ctrl,
    output logic [aptx_pkg::BYTE_W-1:0] o_lcd_clock_timer,
    output logic [aptx_pkg::BYTE_W-1:0] o_lcd_timer_reload,
    output logic [aptx_pkg::BYTE_W-1:0] o_prescaler_counter,
    output logic [aptx_pkg::BYTE_W-1:0] o_prescaler_reload,
    output logic [aptx_pkg::BYTE_W-1:0] o_timer_one_reload,
    output logic [2:0] o_clock_ctrl_aux,
    output logic o_timer_ctrl_bit
);
    import aptx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode and bus

    logic [NREG-1:0] nib_wr;
    logic lcd_timer_wr;
    logic prescale_wr;
    logic tmr1_wr;
    logic aux_wr;
    logic tbit_wr;
    logic store_wr;
    logic hit;

    aptx_decode u_decode (
        .i_insn(i_insn),
        .i_valid(i_insn_valid),
        .o_nib_wr(nib_wr),
        .o_lcd_timer_wr(lcd_timer_wr),
        .o_prescale_wr(prescale_wr),
        .o_tmr1_reload_wr(tmr1_wr),
        .o_clk_aux_wr(aux_wr),
        .o_tmr_bit_wr(tbit_wr),
        .o_store_wr(store_wr),
        .o_hit(hit)
    );

    logic [31:0] rd_data;
    logic rd_ok;
    logic bus_wr;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata;
    logic pready_w;
    logic pslverr_w;
    logic [31:0] prdata_w;

    aptx_apb u_apb (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .o_pready(pready_w),
        .o_pslverr(pslverr_w),
        .o_prdata(prdata_w),
        .i_rd_data(rd_data),
        .i_rd_ok(rd_ok),
        .o_wr_en(bus_wr),
        .o_wr_addr(bus_addr),
        .o_wr_data(bus_wdata)
    );

    // bus reads see state; bus writes only to x (debug preset of the pointer)
    assign o_pready = pready_w;
    assign o_pslverr = pslverr_w;
    assign o_prdata = prdata_w;

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [NIB_W-1:0] ctrl_reg [NREG];
    logic [BYTE_W-1:0] lcd_timer_reg;
    logic [BYTE_W-1:0] lcd_reload_reg;
    logic [BYTE_W-1:0] pre_cnt_reg;
    logic [BYTE_W-1:0] pre_reload_reg;
    logic [BYTE_W-1:0] tmr1_reload_reg;
    logic [2:0] aux_reg;
    logic tbit_reg;
    logic [NIB_W-1:0] x_reg;
    logic ram_we_reg;
    logic [RAM_AW-1:0] ram_addr_reg;
    logic [NIB_W-1:0] ram_wdata_reg;
    logic done_reg;
    logic carry_reg;
    logic skip_reg;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // bus words carry register contents in their low bits
    function automatic logic [31:0] word_of8(input logic [BYTE_W-1:0] v);
        word_of8 = {24'h00_0000, v};
    endfunction : word_of8

    function automatic logic [31:0] word_of4(input logic [NIB_W-1:0] v);
        word_of4 = {28'h000_0000, v};
    endfunction : word_of4

    // b above a, the pairing of the prescaler and timer-one reload loads
    function automatic logic [BYTE_W-1:0] pair_of(input logic [NIB_W-1:0] hi,
        input logic [NIB_W-1:0] lo);
        pair_of = {hi, lo};
    endfunction : pair_of

    // acc alone into an 8-bit register, upper half cleared
    function automatic logic [BYTE_W-1:0] widen_nib(input logic [NIB_W-1:0] v);
        widen_nib = {4'h0, v};
    endfunction : widen_nib

    ////////////////////////////////////////////////////////////////////////////
    // write path

    wire logic [BYTE_W-1:0] pair_ba = pair_of(i_b, i_acc);
    wire logic [NIB_W-1:0] imm_j = i_insn[3:0];
    // bus preset of x is a debug aid only; a same-cycle store owns x
    wire logic bus_x_wr = bus_wr & (bus_addr == ADDR_X);
    wire logic [NIB_W-1:0] x_next = store_wr ? (x_reg ^ imm_j)
        : bus_x_wr ? bus_wdata[3:0] : x_reg;

    genvar g;
    generate
        for (g = 0; g < NREG; g++)
        begin : g_nib
            always_ff @(posedge i_clock or negedge i_resetn)
            begin
                if (!i_resetn)
                    ctrl_reg[g] <= RST_NIB;
                else if (nib_wr[g])
                    ctrl_reg[g] <= i_acc;
            end
            assign o_ctrl[g*NIB_W +: NIB_W] = ctrl_reg[g];
        end
    endgenerate

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            lcd_timer_reg <= RST_BYTE;
            lcd_reload_reg <= RST_BYTE;
        end
        else if (lcd_timer_wr)
        begin
            // 4-bit acc zero-extended into both 8-bit registers
            lcd_timer_reg <= widen_nib(i_acc);
            lcd_reload_reg <= widen_nib(i_acc);
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pre_cnt_reg <= RST_BYTE;
            pre_reload_reg <= RST_BYTE;
        end
        else if (prescale_wr)
        begin
            pre_cnt_reg <= pair_ba;
            pre_reload_reg <= pair_ba;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            tmr1_reload_reg <= RST_BYTE;
        else if (tmr1_wr)
            tmr1_reload_reg <= pair_ba;
    end

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            aux_reg <= RST_AUX;
        else if (aux_wr)
            aux_reg <= i_acc[2:0];
    end

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            tbit_reg <= 1'b0;
        else if (tbit_wr)
            tbit_reg <= i_acc[0];
    end

    // ram store: one-cycle write strobe registered with address and data
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ram_we_reg <= 1'b0;
            ram_addr_reg <= '0;
            ram_wdata_reg <= RST_NIB;
        end
        else
        begin
            ram_we_reg <= store_wr;
            ram_addr_reg <= i_data_pointer;
            ram_wdata_reg <= i_acc;
        end
    end

    // x is xored with the store immediate, else takes a bus preset
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            x_reg <= RST_NIB;
        else
            x_reg <= x_next;
    end

    // completion pulse, one cycle per group instruction
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            done_reg <= 1'b0;
        else
            done_reg <= hit;
    end

    // carry passes through untouched
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            carry_reg <= 1'b0;
        else
            carry_reg <= i_carry;
    end

    // no transfer skips; a flop so that the pin stays registered
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            skip_reg <= 1'b0;
        else
            skip_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    wire logic [7:0] addr = i_paddr;
    wire logic nib_sel = (addr[1:0] == 2'b00) && (addr[7:2] < 6'(NREG));
    wire logic [4:0] nib_idx = addr[6:2];
    wire logic [NIB_W-1:0] nib_val = ctrl_reg[nib_sel ? nib_idx : 5'd0];

    // one select per wide place; an address outside the map answers with an error
    wire logic sel_lcd_timer = (addr == ADDR_LCD_TIMER);
    wire logic sel_lcd_reload = (addr == ADDR_LCD_RELOAD);
    wire logic sel_prescale = (addr == ADDR_PRESCALE);
    wire logic sel_pre_reload = (addr == ADDR_PRE_RELOAD);
    wire logic sel_tmr1_reload = (addr == ADDR_TMR1_RELOAD);
    wire logic sel_clk_aux = (addr == ADDR_CLK_AUX);
    wire logic sel_tmr_bit = (addr == ADDR_TMR_BIT);
    wire logic sel_x = (addr == ADDR_X);
    wire logic sel_status = (addr == ADDR_STATUS);

    assign rd_ok = nib_sel | sel_lcd_timer | sel_lcd_reload | sel_prescale | sel_pre_reload
        | sel_tmr1_reload | sel_clk_aux | sel_tmr_bit | sel_x | sel_status;
    assign rd_data = ({32{nib_sel}} & word_of4(nib_val))
        | ({32{sel_lcd_timer}} & word_of8(lcd_timer_reg))
        | ({32{sel_lcd_reload}} & word_of8(lcd_reload_reg))
        | ({32{sel_prescale}} & word_of8(pre_cnt_reg))
        | ({32{sel_pre_reload}} & word_of8(pre_reload_reg))
        | ({32{sel_tmr1_reload}} & word_of8(tmr1_reload_reg))
        | ({32{sel_clk_aux}} & word_of4({1'b0, aux_reg}))
        | ({32{sel_tmr_bit}} & word_of4({3'h0, tbit_reg}))
        | ({32{sel_x}} & word_of4(x_reg))
        | ({32{sel_status}} & word_of4({3'h0, done_reg}));

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_ram_we = ram_we_reg;
    assign o_ram_addr = ram_addr_reg;
    assign o_ram_wdata = ram_wdata_reg;
    assign o_x = x_reg;
    assign o_carry = carry_reg;
    assign o_skip = skip_reg;
    assign o_done = done_reg;
    assign o_lcd_clock_timer = lcd_timer_reg;
    assign o_lcd_timer_reload = lcd_reload_reg;
    assign o_prescaler_counter = pre_cnt_reg;
    assign o_prescaler_reload = pre_reload_reg;
    assign o_timer_one_reload = tmr1_reload_reg;
    assign o_clock_ctrl_aux = aux_reg;
    assign o_timer_ctrl_bit = tbit_reg;

endmodule : aptx_xfer

`default_nettype wire

/* File: testbench/aptx_xfer_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module aptx_xfer_chk
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // instruction side
    input wire logic i_insn_valid,
    input wire logic [aptx_pkg::INSN_W-1:0] i_insn,
    input wire logic [aptx_pkg::NIB_W-1:0] i_acc,
    input wire logic [aptx_pkg::NIB_W-1:0] i_b,
    input wire logic [aptx_pkg::RAM_AW-1:0] i_data_pointer,
    input wire logic i_carry,
    // observed outputs
    input wire logic o_ram_we,
    input wire logic [aptx_pkg::RAM_AW-1:0] o_ram_addr,
    input wire logic [aptx_pkg::NIB_W-1:0] o_ram_wdata,
    input wire logic [aptx_pkg::NIB_W-1:0] o_x,
    input wire logic o_carry,
    input wire logic o_skip,
    input wire logic o_done,
    input wire logic [aptx_pkg::NREG*aptx_pkg::NIB_W-1:0] o_ctrl,
    input wire logic [aptx_pkg::BYTE_W-1:0] o_lcd_clock_timer,
    input wire logic [aptx_pkg::BYTE_W-1:0] o_lcd_timer_reload,
    input wire logic [aptx_pkg::BYTE_W-1:0] o_prescaler_counter,
    input wire logic [aptx_pkg::BYTE_W-1:0] o_prescaler_reload,
    input wire logic [aptx_pkg::BYTE_W-1:0] o_timer_one_reload,
    input wire logic [2:0] o_clock_ctrl_aux,
    input wire logic o_timer_ctrl_bit
);
    import aptx_pkg::*;

    wire store_op = i_insn_valid && (i_insn[9:4] == OP_STORE_HI);

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    sequence store_seq;
        store_op;
    endsequence
    sequence ram_write_seq;
        ##1 o_ram_we && o_ram_addr == $past(i_data_pointer) && o_ram_wdata == $past(i_acc);
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    store_ram_a: assert property (store_seq |-> ram_write_seq)
        else $error("store did not write ram");
    x_xor_a: assert property (store_seq |=> o_x == ($past(o_x) ^ $past(i_insn[3:0])))
        else $error("x not xored with immediate");
    ram_cause_a: assert property (o_ram_we |-> $past(store_op))
        else $error("ram write without store");
    prescale_pair_a: assert property (i_insn_valid && i_insn == OP_PRESCALE |=>
        o_prescaler_counter == {$past(i_b), $past(i_acc)} && o_prescaler_reload == o_prescaler_counter)
        else $error("prescaler pair wrong");
    tmr1_reload_a: assert property (i_insn_valid && i_insn == OP_TMR1_RELOAD |=>
        o_timer_one_reload == {$past(i_b), $past(i_acc)})
        else $error("timer one reload wrong");
    lcd_timer_a: assert property (i_insn_valid && i_insn == OP_LCD_TIMER |=>
        o_lcd_clock_timer == {4'h0, $past(i_acc)} && o_lcd_timer_reload == o_lcd_clock_timer)
        else $error("lcd timer pair wrong");
    aux_clock_a: assert property (i_insn_valid && i_insn == OP_CLK_AUX |=>
        {1'b0, o_clock_ctrl_aux} == ($past(i_acc) & 4'h7))
        else $error("aux clock wrong");
    tmr_bit_a: assert property (i_insn_valid && i_insn == OP_TMR_BIT |=>
        {3'h0, o_timer_ctrl_bit} == ($past(i_acc) & 4'h1))
        else $error("timer bit wrong");
    port_drv_a: assert property (i_insn_valid && i_insn == OP_PORT_DRV3 |=>
        o_ctrl[3:0] == $past(i_acc))
        else $error("port drive three wrong");
    carry_keep_a: assert property (1'b1 |=> o_carry == $past(i_carry))
        else $error("carry altered");
    no_skip_a: assert property (!o_skip)
        else $error("skip raised");
    done_cause_a: assert property (o_done |-> $past(i_insn_valid))
        else $error("done without instruction");
endmodule : aptx_xfer_chk

bind aptx_xfer aptx_xfer_chk chk (.i_clock, .i_resetn, .i_insn_valid, .i_insn, .i_acc, .i_b,
    .i_data_pointer, .i_carry, .o_ram_we, .o_ram_addr, .o_ram_wdata, .o_x, .o_carry, .o_skip,
    .o_done, .o_ctrl, .o_lcd_clock_timer, .o_lcd_timer_reload, .o_prescaler_counter,
    .o_prescaler_reload, .o_timer_one_reload, .o_clock_ctrl_aux, .o_timer_ctrl_bit);

`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import aptx_pkg::*;

    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic i_insn_valid = 1'b0;
    logic i_carry = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [INSN_W-1:0] i_insn = '0;
    logic [NIB_W-1:0] i_acc = '0;
    logic [NIB_W-1:0] i_b = '0;
    logic [RAM_AW-1:0] i_data_pointer = '0;
    logic [7:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0;
    logic o_pready, o_pslverr, o_ram_we, o_carry, o_skip, o_done, o_timer_ctrl_bit;
    logic [31:0] o_prdata;
    logic [RAM_AW-1:0] o_ram_addr;
    logic [NIB_W-1:0] o_ram_wdata, o_x;
    logic [NREG*NIB_W-1:0] o_ctrl, ctrl_m;
    logic [BYTE_W-1:0] o_lcd_clock_timer, o_lcd_timer_reload, o_prescaler_counter;
    logic [BYTE_W-1:0] o_prescaler_reload, o_timer_one_reload;
    logic [2:0] o_clock_ctrl_aux;
    // index order of the nibble bank
    logic [9:0] nib_ops [NREG] = '{OP_PORT_DRV3, OP_INT_CTRL1, OP_INT_EN1, OP_INT_EN2, OP_WAKE0,
        OP_WAKE1, OP_WAKE2, OP_WAKE3, OP_LCD1, OP_LCD2, OP_LCD3, OP_CLK_MAIN, OP_PULLUP0,
        OP_PULLUP1, OP_PULLUP2, OP_PULLUP3, OP_TMR_CTRL1, OP_TMR_CTRL2};
    int failures = 0;
    int check_count = 0;
    logic [NIB_W-1:0] a, b, x_m;
    logic [BYTE_W-1:0] pre_m;
    logic [31:0] rd;
    logic err;

    always #5 i_clock = ~i_clock;

    aptx_xfer dut (.i_clock, .i_resetn, .i_insn_valid, .i_insn, .i_acc, .i_b, .i_data_pointer,
        .i_carry, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr,
        .o_prdata, .o_ram_we, .o_ram_addr, .o_ram_wdata, .o_x, .o_carry, .o_skip, .o_done,
        .o_ctrl, .o_lcd_clock_timer, .o_lcd_timer_reload, .o_prescaler_counter,
        .o_prescaler_reload, .o_timer_one_reload, .o_clock_ctrl_aux, .o_timer_ctrl_bit);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    function automatic logic [7:0] pair(input logic [3:0] hi, input logic [3:0] lo);
        return {hi, lo};
    endfunction : pair

    // one instruction, idle cycle after so valid never lingers
    task automatic run(input logic [9:0] op, input logic hit);
        logic c;
        c = 1'($urandom);
        @(posedge i_clock);
        i_insn <= op;
        i_acc <= a;
        i_b <= b;
        i_carry <= c;
        i_data_pointer <= 9'($urandom);
        i_insn_valid <= 1'b1;
        @(posedge i_clock);
        i_insn_valid <= 1'b0;
        #1;
        check({o_carry, o_skip, o_done}, {c, 1'b0, hit});
    endtask : run

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= addr;
        i_pwdata <= wd;
        @(posedge i_clock);
        i_penable <= 1'b1;
        // look just after each edge: what stands then is what the next edge samples
        for (n = 0; n < 16; n++)
        begin
            #1;
            if (o_pready === 1'b1)
                break;
            @(posedge i_clock);
        end
        if (n == 16)
        begin
            failures++;
            stop_test();
        end
        rd = o_prdata;
        err = o_pslverr;
        @(posedge i_clock);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        #1;
    endtask : apb

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge i_clock);
        failures++;
        stop_test();
    end

    initial
    begin
        void'($urandom(32'h75a0ec1b));
        x_m = 4'h0;
        ctrl_m = '0;
        repeat (6) @(posedge i_clock);
        i_resetn <= 1'b1;
        #1;
        check({o_ctrl, o_x, o_ram_we}, '0);
        // random pass, then all-ones and all-zeros corners
        for (int k = 0; k < 2 * NREG; k++)
        begin
            a = (k < NREG) ? 4'($urandom) : {4{k[0]}};
            b = 4'($urandom);
            run(nib_ops[k % NREG], 1'b1);
            ctrl_m[4 * (k % NREG) +: 4] = a;
            check(o_ctrl, ctrl_m);
        end
        @(posedge i_clock);
        i_insn <= OP_WAKE0;
        i_acc <= 4'ha;
        i_insn_valid <= 1'b1;
        @(posedge i_clock);
        i_insn <= OP_WAKE3;
        i_acc <= 4'h5;
        @(posedge i_clock);
        i_insn_valid <= 1'b0;
        #1;
        ctrl_m[19:16] = 4'ha;
        ctrl_m[31:28] = 4'h5;
        check(o_ctrl, ctrl_m);
        repeat (4)
        begin
            a = 4'($urandom);
            b = 4'($urandom);
            run(OP_LCD_TIMER, 1'b1);
            check({o_lcd_clock_timer, o_lcd_timer_reload}, {pair(4'h0, a), pair(4'h0, a)});
            run(OP_PRESCALE, 1'b1);
            check({o_prescaler_counter, o_prescaler_reload}, {pair(b, a), pair(b, a)});
            pre_m = pair(b, a);
            run(OP_TMR1_RELOAD, 1'b1);
            check(o_timer_one_reload, pair(b, a));
            run(OP_CLK_AUX, 1'b1);
            check(o_clock_ctrl_aux, a[2:0]);
            run(OP_TMR_BIT, 1'b1);
            check(o_timer_ctrl_bit, a[0]);
        end
        check(o_ctrl, ctrl_m);
        a = 4'hf;
        run(10'h00e, 1'b0);
        check({o_ram_we, o_ctrl}, {1'b0, ctrl_m});
        // register view, read-only write and unmapped place
        apb(1'b1, 8'h00, 32'h5);
        apb(1'b0, 8'h00, '0);
        check({err, rd}, {1'b0, 28'h0, ctrl_m[3:0]});
        apb(1'b0, 8'h44, '0);
        check({err, rd}, {1'b0, 28'h0, ctrl_m[71:68]});
        apb(1'b1, ADDR_X, 32'h9);
        x_m = 4'h9;
        apb(1'b0, ADDR_X, '0);
        check(rd, {28'h0, x_m});
        apb(1'b0, ADDR_PRE_RELOAD, '0);
        check({err, rd}, {1'b0, 24'h0, pre_m});
        apb(1'b0, 8'h70, '0);
        check({err, rd}, {1'b1, 32'h0});
        for (int j = 0; j < 16; j++)
        begin
            a = 4'($urandom);
            run({OP_STORE_HI, 4'(j)}, 1'b1);
            x_m = x_m ^ 4'(j);
            check({o_ram_we, o_ram_addr, o_ram_wdata, o_x}, {1'b1, i_data_pointer, a, x_m});
        end
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
